// ---- otg_i2c_host.sv ----
/* serial controller model: register writes and reads.
   assumes a pulled-up data wire whose level comes back on sda_w. */
module otg_i2c_host #(parameter logic [6:0] DEV_ADDR = 7'h2a) (
	input wire logic clk_sys,
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acked = 1'b1;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// one scl phase of four clocks
	task ph;
		repeat (4) @(negedge clk_sys);
	endtask
	// start or repeated start, or stop
	task frame(input logic go);
		sda = go;
		ph;
		scl = 1'b1;
		ph;
		sda = !go;
		ph;
		scl = !go;
	endtask
	// one bit out, wire level back at the high phase
	task bit_io(input logic b, output logic r);
		sda = b;
		ph;
		scl = 1'b1;
		ph;
		r = sda_w;
		scl = 1'b0;
	endtask
	// byte out, block must acknowledge
	task put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		if (r !== 1'b0) acked = 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		frame(1'b1);
		put({DEV_ADDR, 1'b0});
		put(a);
		put(d);
		frame(1'b0);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		logic r;
		frame(1'b1);
		put({DEV_ADDR, 1'b0});
		put(a);
		frame(1'b1);
		put({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, r); // nack ends the read
		frame(1'b0);
	endtask
endmodule

// ---- otg_i2c_target.sv ----
/*
 * two-wire serial target: address match, register pointer, byte writes
 * and reads with pointer increment.
 * assumes scl and sda inputs already synchronous to clk_sys, and a clock
 * far slower than clk_sys so every level is seen for several cycles.
 */
module otg_i2c_target
	import otg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	otg_reg_if.target bus
);
	typedef enum logic [2:0] {
		st_idle, st_addr, st_addr_ack, st_write, st_write_ack, st_read, st_read_ack
	} otg_tgt_state_t;

	otg_tgt_state_t state;
	logic scl_q, sda_q, full, rw, ptr_pending, nack, drive_low;
	logic [7:0] shreg, ptr;
	logic [2:0] bitcnt;
	logic scl_rise, scl_fall, start_seen, stop_seen;

	// line events from the previous sample
	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
	assign sda_out = 1'b0; // open drain: only ever pulls low
	assign sda_oe = drive_low;
	assign bus.rd_addr = ptr;

	// previous line levels
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// protocol sequencer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			shreg <= RESET_REG;
			ptr <= RESET_REG;
			bitcnt <= 3'h0;
			full <= 1'b0;
			rw <= 1'b0;
			ptr_pending <= 1'b0;
			nack <= 1'b0;
			drive_low <= 1'b0;
			bus.wr_stb <= 1'b0;
			bus.wr_addr <= RESET_REG;
			bus.wr_data <= RESET_REG;
		end else begin
			bus.wr_stb <= 1'b0;
			if (start_seen) begin
				state <= st_addr;
				bitcnt <= 3'h0;
				full <= 1'b0;
				drive_low <= 1'b0;
			end else if (stop_seen) begin
				state <= st_idle;
				drive_low <= 1'b0;
			end else begin
				unique case (state)
					st_idle: begin
						drive_low <= 1'b0;
					end
					st_addr, st_write: begin
						if (scl_rise && !full) begin
							shreg <= {shreg[6:0], sda_in};
							bitcnt <= bitcnt + 3'h1;
							full <= (bitcnt == LAST_BIT);
						end else if (scl_fall && full) begin
							full <= 1'b0;
							if (state == st_addr) begin
								rw <= shreg[0];
								drive_low <= (shreg[7:1] == DEV_ADDR);
								state <= (shreg[7:1] == DEV_ADDR) ? st_addr_ack : st_idle;
							end else begin
								drive_low <= 1'b1;
								state <= st_write_ack;
								if (ptr_pending) begin
									ptr <= shreg; // first byte sets the register pointer
									ptr_pending <= 1'b0;
								end else begin
									bus.wr_stb <= 1'b1;
									bus.wr_addr <= ptr;
									bus.wr_data <= shreg;
									ptr <= ptr + 8'h01;
								end
							end
						end
					end
					st_addr_ack: begin
						if (scl_fall) begin
							bitcnt <= 3'h0;
							if (rw) begin
								shreg <= bus.rd_data;
								drive_low <= ~bus.rd_data[7];
								state <= st_read;
							end else begin
								drive_low <= 1'b0;
								ptr_pending <= 1'b1;
								state <= st_write;
							end
						end
					end
					st_write_ack: begin
						if (scl_fall) begin
							drive_low <= 1'b0;
							bitcnt <= 3'h0;
							state <= st_write;
						end
					end
					st_read: begin
						if (scl_fall) begin
							if (bitcnt == LAST_BIT) begin
								drive_low <= 1'b0; // release for the controller's ack
								ptr <= ptr + 8'h01;
								state <= st_read_ack;
							end else begin
								shreg <= {shreg[6:0], 1'b0};
								drive_low <= ~shreg[6];
								bitcnt <= bitcnt + 3'h1;
							end
						end
					end
					st_read_ack: begin
						if (scl_rise) begin
							nack <= sda_in;
						end else if (scl_fall) begin
							bitcnt <= 3'h0;
							if (nack) begin
								state <= st_idle;
							end else begin
								shreg <= bus.rd_data;
								drive_low <= ~bus.rd_data[7];
								state <= st_read;
							end
						end
					end
				endcase
			end
		end
	end
endmodule

// ---- otg_irq_gpio_regs.sv ----
/*
 * interrupt latch, edge masks and general pin registers of an otg
 * transceiver, reached through a two-wire serial target.
 * assumes event sources and pin inputs synchronous to clk_sys.
 */
// Behaviour
// - sticky event and pin latches, set/clear pairs
// - falling mask enables true-to-false interrupts
// - clearing mask bit stops that edge
// - rising mask enables false-to-true interrupts
// - direction set makes pin output
// - direction clear makes pin input
// - level set drives pin high
// - level clear drives pin low
// - input register returns sampled pin levels
// - fixed event bit positions everywhere
// - set/clear addresses read contents; ones act
module otg_irq_gpio_regs
	import otg_pkg::*;
#(
	parameter int NUM_PINS = 3,
	parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [7:0] event_src,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe,
	output logic irq
);
	if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
		$error("NUM_PINS must be 1 to 8");
	end

	localparam logic [7:0] PIN_MASK = 8'(16'h00ff >> (8 - NUM_PINS));

	otg_reg_if bus ();

	// stored registers
	logic [7:0] event_latch;
	logic [7:0] falling_mask;
	logic [7:0] rising_mask;
	logic [7:0] pin_direction;
	logic [7:0] pin_level;
	logic [7:0] pin_event_latch;
	// last samples of the sources and pins
	logic [7:0] src_state;
	logic [7:0] pin_state;
	logic sampled;
	// edge terms
	logic [7:0] src_rise;
	logic [7:0] src_fall;
	logic [7:0] event_hit;
	logic [7:0] pin_hit;
	// write data and decoded write strobes
	logic [7:0] wr_set;
	logic [7:0] wr_clr;
	logic [7:0] pin_in_wide;
	logic wr_event_set;
	logic wr_event_clr;
	logic wr_pin_event_set;
	logic wr_pin_event_clr;
	logic wr_falling_set;
	logic wr_falling_clr;
	logic wr_rising_set;
	logic wr_rising_clr;
	logic wr_dir_set;
	logic wr_dir_clr;
	logic wr_level_set;
	logic wr_level_clr;

	otg_i2c_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_target (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.bus(bus)
	);

	assign pin_in_wide = 8'(pin_in);

	// source and pin sampling; the first sample after reset raises no edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			src_state <= RESET_REG;
			pin_state <= RESET_REG;
			sampled <= 1'b0;
		end else begin
			src_state <= event_src;
			pin_state <= pin_in_wide & PIN_MASK;
			sampled <= 1'b1;
		end
	end

	// edge detection against the last sample; source edges gated by the masks, any pin change counts
	assign src_rise = sampled ? (event_src & ~src_state) : RESET_REG;
	assign src_fall = sampled ? (~event_src & src_state) : RESET_REG;
	assign event_hit = (src_rise & rising_mask) | (src_fall & falling_mask);
	assign pin_hit = sampled ? ((pin_in_wide & PIN_MASK) ^ pin_state) : RESET_REG;

	// write data spread over the set and clear halves of a pair
	assign wr_set = bus.wr_stb ? bus.wr_data : RESET_REG;
	assign wr_clr = bus.wr_stb ? bus.wr_data : RESET_REG;

	// one strobe per writable address; read-only and unmapped ones decode to nothing
	assign wr_event_set = bus.wr_stb && (bus.wr_addr == ADDR_EVENT_LATCH_SET);
	assign wr_event_clr = bus.wr_stb && (bus.wr_addr == ADDR_EVENT_LATCH_CLEAR);
	assign wr_pin_event_set = bus.wr_stb && (bus.wr_addr == ADDR_PIN_EVENT_LATCH_SET);
	assign wr_pin_event_clr = bus.wr_stb && (bus.wr_addr == ADDR_PIN_EVENT_LATCH_CLEAR);
	assign wr_falling_set = bus.wr_stb && (bus.wr_addr == ADDR_FALLING_MASK_SET);
	assign wr_falling_clr = bus.wr_stb && (bus.wr_addr == ADDR_FALLING_MASK_CLEAR);
	assign wr_rising_set = bus.wr_stb && (bus.wr_addr == ADDR_RISING_MASK_SET);
	assign wr_rising_clr = bus.wr_stb && (bus.wr_addr == ADDR_RISING_MASK_CLEAR);
	assign wr_dir_set = bus.wr_stb && (bus.wr_addr == ADDR_PIN_DIRECTION_SET);
	assign wr_dir_clr = bus.wr_stb && (bus.wr_addr == ADDR_PIN_DIRECTION_CLEAR);
	assign wr_level_set = bus.wr_stb && (bus.wr_addr == ADDR_PIN_LEVEL_SET);
	assign wr_level_clr = bus.wr_stb && (bus.wr_addr == ADDR_PIN_LEVEL_CLEAR);

	// event latch: hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			event_latch <= RESET_REG;
		end else if (wr_event_set) begin
			event_latch <= event_latch | wr_set | event_hit;
		end else if (wr_event_clr) begin
			event_latch <= (event_latch & ~wr_clr) | event_hit;
		end else begin
			event_latch <= event_latch | event_hit;
		end
	end

	// pin event latch: any level change on an implemented pin
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_event_latch <= RESET_REG;
		end else if (wr_pin_event_set) begin
			pin_event_latch <= (pin_event_latch | wr_set | pin_hit) & PIN_MASK;
		end else if (wr_pin_event_clr) begin
			pin_event_latch <= ((pin_event_latch & ~wr_clr) | pin_hit) & PIN_MASK;
		end else begin
			pin_event_latch <= pin_event_latch | pin_hit;
		end
	end

	// falling edge mask
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			falling_mask <= RESET_REG;
		end else if (wr_falling_set) begin
			falling_mask <= falling_mask | wr_set;
		end else if (wr_falling_clr) begin
			falling_mask <= falling_mask & ~wr_clr;
		end
	end

	// rising edge mask
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rising_mask <= RESET_REG;
		end else if (wr_rising_set) begin
			rising_mask <= rising_mask | wr_set;
		end else if (wr_rising_clr) begin
			rising_mask <= rising_mask & ~wr_clr;
		end
	end

	// pin direction, only implemented pins can be set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_direction <= RESET_REG;
		end else if (wr_dir_set) begin
			pin_direction <= (pin_direction | wr_set) & PIN_MASK;
		end else if (wr_dir_clr) begin
			pin_direction <= pin_direction & ~wr_clr;
		end
	end

	// pin output level, only implemented pins can be set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_level <= RESET_REG;
		end else if (wr_level_set) begin
			pin_level <= (pin_level | wr_set) & PIN_MASK;
		end else if (wr_level_clr) begin
			pin_level <= pin_level & ~wr_clr;
		end
	end

	// per-pin drive: level and direction go out unmasked, each on its own output
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		assign pin_out[i] = pin_level[i];
		assign pin_oe[i] = pin_direction[i];
	end

	// interrupt stays up while any latch bit is set
	assign irq = |event_latch | |pin_event_latch;

	// read mux: both addresses of a pair return the same contents
	always_comb begin
		unique case (bus.rd_addr)
			ADDR_SOURCE_STATE: bus.rd_data = src_state;
			ADDR_EVENT_LATCH_SET, ADDR_EVENT_LATCH_CLEAR: bus.rd_data = event_latch;
			ADDR_FALLING_MASK_SET, ADDR_FALLING_MASK_CLEAR: bus.rd_data = falling_mask;
			ADDR_RISING_MASK_SET, ADDR_RISING_MASK_CLEAR: bus.rd_data = rising_mask;
			ADDR_PIN_DIRECTION_SET, ADDR_PIN_DIRECTION_CLEAR: bus.rd_data = pin_direction;
			ADDR_PIN_LEVEL_SET, ADDR_PIN_LEVEL_CLEAR: bus.rd_data = pin_level;
			ADDR_PIN_INPUT_STATE: bus.rd_data = pin_state;
			ADDR_PIN_EVENT_LATCH_SET, ADDR_PIN_EVENT_LATCH_CLEAR: bus.rd_data = pin_event_latch;
			default: bus.rd_data = RESET_READ_UNMAPPED;
		endcase
	end
endmodule

// ---- otg_irq_gpio_regs_assertions.sv ----
/* port checker of the otg interrupt and pin register block.
   assumes binding onto the block top, scl phases of several clocks. */
module otg_irq_gpio_regs_assertions #(parameter int NUM_PINS = 3) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [7:0] event_src,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// serial answer timing
	sda_low_only_a: assert property (sda_out == 1'b0)
		else $error("sda_out high");
	sda_oe_stable_a: assert property (scl_in |-> $stable(sda_oe))
		else $error("sda_oe moved in clock high");
	oe_after_fall_a: assert property ($changed(sda_oe) |-> $past(scl_in, 2) && !$past(scl_in))
		else $error("sda_oe moved off fall");
	// register effects and interrupt
	pin_reg_timing_a: assert property (!$stable({pin_oe, pin_out}) |-> !scl_in)
		else $error("pin regs moved in clock high");
	irq_clear_timing_a: assert property ($fell(irq) |-> !scl_in)
		else $error("irq fell without write");
	pin_edge_irq_a: assert property ($past(nrst, 2) && pin_in != $past(pin_in) |-> ##[0:3] irq)
		else $error("pin change not latched");
	irq_rise_cause_a: assert property ($rose(irq) |->
		!scl_in || event_src != $past(event_src, 3) || pin_in != $past(pin_in, 3))
		else $error("irq rose without cause");
	reset_quiet_a: assert property ($rose(nrst) |->
		!irq && !sda_oe && pin_oe == '0 && pin_out == '0)
		else $error("outputs not quiet after reset");
	cover property ($rose(irq));
	cover property ($fell(irq));
	cover property ($rose(sda_oe));
endmodule

// ---- otg_irq_gpio_regs_tb.sv ----
/* self-checking bench of the otg register block via the serial model.
   assumes the hand-over timing of the serial target. */
module otg_irq_gpio_regs_tb
	import otg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] event_src = 8'h00;
	logic [2:0] pin_in = 3'h0;
	logic [2:0] pin_out;
	logic [2:0] pin_oe;
	logic scl;
	logic sda;
	logic sda_oe;
	logic sda_out;
	logic irq;
	logic [7:0] rv;
	int errors = 0;
	int comparisons = 0;
	logic [7:0] addrs [8] = '{8'h0a, 8'h0c, 8'h0e, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h30};
	// open-drain wire with pull-up
	wire logic sda_w = sda & ~(sda_oe & ~sda_out);
	always #2.5 clk_sys = ~clk_sys;
	otg_irq_gpio_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .event_src(event_src), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	otg_i2c_host host (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda(sda));
	task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rv);
		chk($sformatf("reg %h", a), rv, exp);
	endtask
	// new input levels, then time to sample
	task set_in(input logic [7:0] e, input logic [2:0] p);
		@(negedge clk_sys);
		event_src = e;
		pin_in = p;
		repeat (6) @(negedge clk_sys);
	endtask
	task final_report;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// reset values, unmapped read
	task t_reset;
		chk("irq", {7'h0, irq}, 8'h00);
		foreach (addrs[i]) rchk(addrs[i], RESET_REG);
	endtask
	// edge masks and event latch
	task t_events;
		host.wr(ADDR_RISING_MASK_SET, 8'h01);
		rchk(ADDR_RISING_MASK_CLEAR, 8'h01);
		set_in(8'h01, 3'h0);
		chk("irq", {7'h0, irq}, 8'h01);
		rchk(ADDR_EVENT_LATCH_SET, 8'h01);
		host.wr(ADDR_EVENT_LATCH_CLEAR, 8'hff);
		chk("irq", {7'h0, irq}, 8'h00);
		host.wr(ADDR_FALLING_MASK_SET, 8'h01);
		set_in(8'h00, 3'h0);
		rchk(ADDR_EVENT_LATCH_CLEAR, 8'h01);
		host.wr(ADDR_EVENT_LATCH_CLEAR, 8'h01);
		host.wr(ADDR_FALLING_MASK_CLEAR, 8'h01);
		host.wr(ADDR_RISING_MASK_CLEAR, 8'h01);
		set_in(8'h01, 3'h0);
		set_in(8'h00, 3'h0);
		rchk(ADDR_EVENT_LATCH_SET, 8'h00);
		host.wr(ADDR_RISING_MASK_SET, 8'hff);
		set_in(8'ha5, 3'h0);
		rchk(ADDR_SOURCE_STATE, 8'ha5);
		rchk(ADDR_EVENT_LATCH_SET, 8'ha5);
		host.wr(ADDR_EVENT_LATCH_CLEAR, 8'h21);
		rchk(ADDR_EVENT_LATCH_SET, 8'h84);
		host.wr(ADDR_EVENT_LATCH_SET, 8'h10);
		rchk(ADDR_EVENT_LATCH_CLEAR, 8'h94);
	endtask
	// pin direction, level, input and pin latch
	task t_pins;
		host.wr(ADDR_EVENT_LATCH_CLEAR, 8'hff);
		host.wr(ADDR_PIN_DIRECTION_SET, 8'hff);
		chk("pin_oe", {5'h0, pin_oe}, 8'h07);
		rchk(ADDR_PIN_DIRECTION_CLEAR, 8'h07);
		host.wr(ADDR_PIN_LEVEL_SET, 8'h05);
		chk("pin_out", {5'h0, pin_out}, 8'h05);
		host.wr(ADDR_PIN_LEVEL_CLEAR, 8'h01);
		chk("pin_out", {5'h0, pin_out}, 8'h04);
		host.wr(ADDR_PIN_DIRECTION_CLEAR, 8'h02);
		chk("pin_oe", {5'h0, pin_oe}, 8'h05);
		set_in(8'ha5, 3'h6);
		rchk(ADDR_PIN_INPUT_STATE, 8'h06);
		host.wr(ADDR_PIN_INPUT_STATE, 8'h01);
		rchk(ADDR_PIN_INPUT_STATE, 8'h06);
		rchk(ADDR_PIN_EVENT_LATCH_SET, 8'h06);
		host.wr(ADDR_PIN_EVENT_LATCH_SET, 8'hf9);
		rchk(ADDR_PIN_EVENT_LATCH_CLEAR, 8'h07);
		chk("irq", {7'h0, irq}, 8'h01);
		host.wr(ADDR_PIN_EVENT_LATCH_CLEAR, 8'hff);
		chk("irq", {7'h0, irq}, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_reset;
		t_events;
		t_pins;
		chk("ack", {7'h0, host.acked}, 8'h01);
		final_report;
	end
	// hang guard
	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		final_report;
	end
endmodule
bind otg_irq_gpio_regs otg_irq_gpio_regs_assertions #(.NUM_PINS(NUM_PINS)) chk_i (
	.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .event_src(event_src), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe), .irq(irq));

// ---- otg_pkg.sv ----
/*
 * constants of the transceiver interrupt and general pin register block:
 * register addresses, event bit positions and reset values.
 * assumes an eight-bit register space reached over a two-wire serial link.
 */
package otg_pkg;
	// source state and paired set/clear addresses of the event registers
	localparam logic [7:0] ADDR_SOURCE_STATE = 8'h08;
	localparam logic [7:0] ADDR_EVENT_LATCH_SET = 8'h0a;
	localparam logic [7:0] ADDR_EVENT_LATCH_CLEAR = 8'h0b;
	localparam logic [7:0] ADDR_FALLING_MASK_SET = 8'h0c;
	localparam logic [7:0] ADDR_FALLING_MASK_CLEAR = 8'h0d;
	localparam logic [7:0] ADDR_RISING_MASK_SET = 8'h0e;
	localparam logic [7:0] ADDR_RISING_MASK_CLEAR = 8'h0f;
	// general pin registers
	localparam logic [7:0] ADDR_PIN_DIRECTION_SET = 8'h14;
	localparam logic [7:0] ADDR_PIN_DIRECTION_CLEAR = 8'h15;
	localparam logic [7:0] ADDR_PIN_LEVEL_SET = 8'h16;
	localparam logic [7:0] ADDR_PIN_LEVEL_CLEAR = 8'h17;
	localparam logic [7:0] ADDR_PIN_INPUT_STATE = 8'h18;
	localparam logic [7:0] ADDR_PIN_EVENT_LATCH_SET = 8'h1a;
	localparam logic [7:0] ADDR_PIN_EVENT_LATCH_CLEAR = 8'h1b;
	// event source bit positions
	localparam int BIT_BUS_VOLTAGE_VALID = 0;
	localparam int BIT_SESSION_VALID = 1;
	localparam int BIT_PLUS_LINE_HIGH = 2;
	localparam int BIT_IDENTITY_GROUNDED = 3;
	localparam int BIT_MINUS_LINE_HIGH = 4;
	localparam int BIT_IDENTITY_OPEN = 5;
	localparam int BIT_SESSION_END = 6;
	localparam int BIT_CAR_KIT_EVENT = 7;
	// values after reset, and the last bit index of a byte
	localparam logic [7:0] RESET_REG = 8'h00;
	localparam logic [7:0] RESET_READ_UNMAPPED = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// ---- otg_reg_if.sv ----
/*
 * register access carrier between the serial target and the register file.
 * assumes one clock domain; the strobe is a single-cycle pulse.
 */
interface otg_reg_if;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	modport target (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
